//--- hdl/tem_pkg.sv
// Package for the TCM ECC error monitor: register map, field layout, codes.
// Assumes a 32-bit AXI4-Lite register bus and one 125 MHz clock.
package tem_pkg;
	localparam logic [11:0] TEM_FLAGS_OFS = 12'hd00;
	localparam logic [11:0] TEM_CTRL_OFS  = 12'hd04;
	localparam logic [11:0] TEM_CODE_OFS  = 12'hd08;
	localparam logic [11:0] TEM_ADDR_OFS  = 12'hd0c;

	localparam int CE_BIT    = 0;
	localparam int UNC_BIT   = 1;
	localparam int MULTI_BIT = 2;

	localparam int CTL_DEN  = 0;
	localparam int CTL_IEN  = 1;
	localparam int CTL_CEM  = 2;
	localparam int CTL_UEM  = 3;
	localparam int CTL_OFM  = 4;
	localparam int CTL_INJ  = 5;
	localparam int CTL_TGT  = 7;
	localparam int CTL_BITS = 9;

	localparam logic [1:0] INJ_NONE = 2'h0;
	localparam logic [1:0] INJ_CE   = 2'h1;
	localparam logic [1:0] INJ_UNC  = 2'h2;

	localparam logic [1:0] TGT_INSTR = 2'h0;
	localparam logic [1:0] TGT_DATA0 = 2'h1;
	localparam logic [1:0] TGT_DATA1 = 2'h2;

	localparam logic [2:0] LOC_NONE  = 3'h0;
	localparam logic [2:0] LOC_INSTR = 3'h1;
	localparam logic [2:0] LOC_DATA  = 3'h2;

	localparam logic [1:0] MT_NONE = 2'h0;
	localparam logic [1:0] MT_CE   = 2'h1;
	localparam logic [1:0] MT_UNC  = 2'h2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int NUM_RAMS = 3;

	// One RAM read report from a checker: the read and its syndrome outcome
	typedef struct packed {
		logic        valid;
		logic        corr;
		logic        uncorr;
		logic [31:0] addr;
	} tem_rd_t;

	// Outcome of one port after injection is applied
	typedef struct packed {
		logic        corr;
		logic        uncorr;
		logic [31:0] addr;
	} tem_hit_t;

	typedef struct packed {
		logic [31:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [31:0] araddr;
		logic        arvalid;
		logic        rready;
	} tem_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} tem_axi_rsp_t;
endpackage : tem_pkg

//--- hdl/tem_port_inject.sv
// Per-RAM injection stage: forces the selected error onto one read report.
// Assumes read reports arrive one cycle wide from the RAM's ECC checker.
`timescale 1ns/100ps
module tem_port_inject (
	input  wire logic            ref_clk,
	input  wire logic            rst,
	input  wire tem_pkg::tem_rd_t rd,
	input  wire logic            checkEn,
	input  wire logic [1:0]      injMode,
	input  wire logic            selected,
	output tem_pkg::tem_hit_t    hit,
	output logic                 injUsed
);
	import tem_pkg::*;

	typedef struct packed {
		tem_hit_t hit;
		logic     injUsed;
	} tem_pi_state_t;

	tem_pi_state_t st;
	tem_pi_state_t next_st;
	logic          take;

	// Inject only on a checked read of the selected RAM
	// The field clears one edge late, so a just-used stage refuses a second read
	always_comb begin
		take = rd.valid && checkEn && selected && !st.injUsed && (injMode == INJ_CE || injMode == INJ_UNC);
		next_st = '0;
		if (rd.valid && checkEn) begin
			next_st.hit.corr   = rd.corr || (take && injMode == INJ_CE);
			next_st.hit.uncorr = rd.uncorr || (take && injMode == INJ_UNC);
			next_st.hit.addr   = rd.addr;
		end
		next_st.injUsed = take;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign hit     = st.hit;
	assign injUsed = st.injUsed;

	a_inj_applied: assert property (@(posedge ref_clk) disable iff (rst)
		(rd.valid && checkEn && selected && !injUsed && injMode == INJ_UNC) |=> hit.uncorr)
		else $error("injected uncorrectable error missing");
	a_inj_ce_applied: assert property (@(posedge ref_clk) disable iff (rst)
		(rd.valid && checkEn && selected && !injUsed && injMode == INJ_CE) |=> hit.corr)
		else $error("injected correctable error missing");
	a_disabled_quiet: assert property (@(posedge ref_clk) disable iff (rst)
		(!checkEn) |=> !(hit.corr || hit.uncorr))
		else $error("disabled RAM reported an error");
endmodule : tem_port_inject

//--- hdl/tem_error_monitor.sv
// TCM ECC error monitor: records, masks and injects RAM ECC errors.
// Assumes AXI4-Lite master on ref_clk and one read report per RAM per cycle.
`timescale 1ns/100ps
module tem_error_monitor (
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire tem_pkg::tem_axi_req_t axiReq,
	output tem_pkg::tem_axi_rsp_t      axiRsp,
	input  wire tem_pkg::tem_rd_t      instrRd,
	input  wire tem_pkg::tem_rd_t      data0Rd,
	input  wire tem_pkg::tem_rd_t      data1Rd,
	output logic                       errIrq
);
	import tem_pkg::*;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_RESP = 3'b010,
		BUS_HOLD = 3'b100
	} tem_wstate_t;

	typedef struct packed {
		tem_wstate_t  wState;
		logic         awHave;
		logic [11:0]  awAddr;
		logic         wHave;
		logic [31:0]  wData;
		logic [3:0]   wStrb;
		logic         rBusy;
		tem_axi_rsp_t rsp;
		logic [2:0]   flags;
		logic [CTL_BITS-1:0] ctrl;
		logic [2:0]   locCode;
		logic [1:0]   multiType;
		logic [31:0]  failAddr;
		logic         irq;
	} tem_state_t;

	tem_state_t st;
	tem_state_t next_st;

	tem_rd_t   rds   [NUM_RAMS];
	tem_hit_t  hits  [NUM_RAMS];
	logic      used  [NUM_RAMS];
	logic      enOf  [NUM_RAMS];
	logic      selOf [NUM_RAMS];

	// Per-RAM enables and target decode; code 11 selects nothing
	always_comb begin
		rds[0]   = instrRd;
		rds[1]   = data0Rd;
		rds[2]   = data1Rd;
		enOf[0]  = st.ctrl[CTL_IEN];
		enOf[1]  = st.ctrl[CTL_DEN];
		enOf[2]  = st.ctrl[CTL_DEN];
		selOf[0] = st.ctrl[CTL_TGT+:2] == TGT_INSTR;
		selOf[1] = st.ctrl[CTL_TGT+:2] == TGT_DATA0;
		selOf[2] = st.ctrl[CTL_TGT+:2] == TGT_DATA1;
	end

	// One injection stage per RAM read path
	genvar gi;
	generate
		for (gi = 0; gi < NUM_RAMS; gi++) begin : g_port
			tem_port_inject u_inj (
				.ref_clk (ref_clk),
				.rst     (rst),
				.rd      (rds[gi]),
				.checkEn (enOf[gi]),
				.injMode (st.ctrl[CTL_INJ+:2]),
				.selected(selOf[gi]),
				.hit     (hits[gi]),
				.injUsed (used[gi])
			);
		end
	endgenerate

	logic        anyCe;
	logic        anyUnc;
	logic        anyInj;
	logic [2:0]  evLoc;
	logic [31:0] evAddr;
	logic        wrFire;
	logic        rdFire;
	logic [2:0]  w1c;
	logic [31:0] rdVal;
	logic        inj;

	// Merge the three paths; instruction RAM wins address capture
	always_comb begin
		anyCe  = 1'b0;
		anyUnc = 1'b0;
		anyInj = 1'b0;
		evLoc  = LOC_NONE;
		evAddr = '0;
		for (int i = NUM_RAMS - 1; i >= 0; i--) begin
			anyCe  = anyCe | hits[i].corr;
			anyUnc = anyUnc | hits[i].uncorr;
			anyInj = anyInj | used[i];
			if (hits[i].corr || hits[i].uncorr) begin
				evLoc  = (i == 0) ? LOC_INSTR : LOC_DATA;
				evAddr = hits[i].addr;
			end
		end
	end

	// Register state, bus slave and recording
	always_comb begin
		next_st = st;
		inj     = st.ctrl[CTL_INJ+:2] == INJ_CE || st.ctrl[CTL_INJ+:2] == INJ_UNC;
		wrFire  = 1'b0;
		w1c     = 3'h0;
		rdFire  = axiReq.arvalid && !st.rBusy;
		rdVal   = '0;

		// Write channels, accepted in either order
		if (axiReq.awvalid && !st.awHave && st.wState == BUS_IDLE) begin
			next_st.awHave = 1'b1;
			next_st.awAddr = axiReq.awaddr[11:0];
		end
		if (axiReq.wvalid && !st.wHave && st.wState == BUS_IDLE) begin
			next_st.wHave = 1'b1;
			next_st.wData = axiReq.wdata;
			next_st.wStrb = axiReq.wstrb;
		end
		next_st.rsp.awready = 1'b0;
		next_st.rsp.wready  = 1'b0;
		case (st.wState)
			BUS_IDLE: begin
				next_st.rsp.awready = !next_st.awHave;
				next_st.rsp.wready  = !next_st.wHave;
				if (st.awHave && st.wHave) begin
					wrFire             = 1'b1;
					next_st.wState     = BUS_RESP;
					next_st.rsp.bvalid = 1'b1;
					next_st.rsp.bresp  = RESP_OKAY;
					if (!(st.awAddr inside {TEM_FLAGS_OFS, TEM_CTRL_OFS, TEM_CODE_OFS, TEM_ADDR_OFS}))
						next_st.rsp.bresp = RESP_SLVERR;
				end
			end
			BUS_RESP: begin
				if (axiReq.bready) begin
					next_st.rsp.bvalid = 1'b0;
					next_st.awHave     = 1'b0;
					next_st.wHave      = 1'b0;
					next_st.wState     = BUS_HOLD;
				end
			end
			BUS_HOLD: begin
				next_st.wState      = BUS_IDLE;
				next_st.rsp.awready = 1'b1;
				next_st.rsp.wready  = 1'b1;
			end
			default: next_st.wState = BUS_IDLE;
		endcase

		// Register writes; low byte lane carries every live bit except control bit 8, which rides byte lane 1
		if (wrFire && st.awAddr == TEM_CTRL_OFS) begin
			if (st.wStrb[0])
				next_st.ctrl[7:0] = st.wData[7:0];
			if (st.wStrb[1])
				next_st.ctrl[8] = st.wData[8];
		end
		if (wrFire && st.awAddr == TEM_FLAGS_OFS && st.wStrb[0])
			w1c = st.wData[2:0];

		// Software clears first so a same-cycle event still lands
		if (w1c[CE_BIT] || w1c[UNC_BIT])
			next_st.locCode = LOC_NONE;
		if (w1c[MULTI_BIT])
			next_st.multiType = MT_NONE;
		next_st.flags = st.flags & ~w1c;

		// Recording path shared by genuine and injected errors
		if (anyCe || anyUnc) begin
			// A new event over a live record, or two kinds at once, is a multiple error
			if (st.flags[CE_BIT] || st.flags[UNC_BIT] || (anyCe && anyUnc)) begin
				next_st.flags[MULTI_BIT] = 1'b1;
				next_st.multiType        = anyUnc ? MT_UNC : MT_CE;
			end
			if (anyCe)
				next_st.flags[CE_BIT] = 1'b1;
			if (anyUnc)
				next_st.flags[UNC_BIT] = 1'b1;
			next_st.locCode  = evLoc;
			next_st.failAddr = evAddr;
		end

		// Injection field self-clears once consumed
		if (anyInj && !(wrFire && st.awAddr == TEM_CTRL_OFS && st.wStrb[0]))
			next_st.ctrl[CTL_INJ+:2] = INJ_NONE;

		// Read channel, one cycle to rvalid
		case (axiReq.araddr[11:0])
			TEM_FLAGS_OFS: rdVal = {29'h0, st.flags};
			TEM_CTRL_OFS:  rdVal = {23'h0, st.ctrl};
			TEM_CODE_OFS:  rdVal = {27'h0, st.multiType, st.locCode};
			TEM_ADDR_OFS:  rdVal = st.failAddr;
			default:       rdVal = '0;
		endcase
		if (rdFire) begin
			next_st.rBusy       = 1'b1;
			next_st.rsp.arready = 1'b0;
			next_st.rsp.rvalid  = 1'b1;
			next_st.rsp.rdata   = rdVal;
			next_st.rsp.rresp   = (axiReq.araddr[11:0] inside
				{TEM_FLAGS_OFS, TEM_CTRL_OFS, TEM_CODE_OFS, TEM_ADDR_OFS}) ? RESP_OKAY : RESP_SLVERR;
		end else if (st.rsp.rvalid && axiReq.rready) begin
			next_st.rsp.rvalid  = 1'b0;
			next_st.rBusy       = 1'b0;
			next_st.rsp.arready = 1'b1;
		end

		// Interrupt from unmasked sticky flags
		next_st.irq = (next_st.flags[CE_BIT] && !next_st.ctrl[CTL_CEM])
			|| (next_st.flags[UNC_BIT] && !next_st.ctrl[CTL_UEM])
			|| (next_st.flags[MULTI_BIT] && !next_st.ctrl[CTL_OFM]);
	end

	// Arready is registered, so it reads low for rBusy cycles
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st             <= '0;
			st.wState      <= BUS_IDLE;
			st.rsp.awready <= 1'b1;
			st.rsp.wready  <= 1'b1;
			st.rsp.arready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign axiRsp = st.rsp;
	assign errIrq = st.irq;

	// Recording: every checked event lands in the sticky record one edge later
	a_ce_sets_flag: assert property (@(posedge ref_clk) disable iff (rst)
		anyCe |=> st.flags[CE_BIT])
		else $error("correctable flag not set");
	a_unc_sets_flag: assert property (@(posedge ref_clk) disable iff (rst)
		anyUnc |=> st.flags[UNC_BIT])
		else $error("uncorrectable flag not set");
	a_multi_sets: assert property (@(posedge ref_clk) disable iff (rst)
		((st.flags[CE_BIT] || st.flags[UNC_BIT]) && (anyCe || anyUnc))
		|=> st.flags[MULTI_BIT] && st.multiType != MT_NONE)
		else $error("multiple error not recorded");
	a_multi_type: assert property (@(posedge ref_clk) disable iff (rst)
		((st.flags[CE_BIT] || st.flags[UNC_BIT] || anyCe) && anyUnc) |=> st.multiType == MT_UNC)
		else $error("multiple error type not uncorrectable");
	a_code_instr: assert property (@(posedge ref_clk) disable iff (rst)
		(hits[0].corr || hits[0].uncorr) |=> st.locCode == LOC_INSTR)
		else $error("instruction RAM code wrong");
	a_code_data: assert property (@(posedge ref_clk) disable iff (rst)
		(!(hits[0].corr || hits[0].uncorr)
			&& (hits[1].corr || hits[1].uncorr || hits[2].corr || hits[2].uncorr))
		|=> st.locCode == LOC_DATA)
		else $error("data RAM code wrong");
	a_addr_capture: assert property (@(posedge ref_clk) disable iff (rst)
		(hits[2].uncorr && !hits[1].uncorr && !hits[1].corr && !hits[0].corr && !hits[0].uncorr)
		|=> st.failAddr == $past(hits[2].addr))
		else $error("failing address not captured");
	a_addr_valid: assert property (@(posedge ref_clk) disable iff (rst)
		(anyCe || anyUnc) |=> st.locCode != LOC_NONE)
		else $error("captured address left with zero code");

	// Software clears, checked only where no new event competes
	a_clear_ce: assert property (@(posedge ref_clk) disable iff (rst)
		(w1c[CE_BIT] && !anyCe && !anyUnc)
		|=> !st.flags[CE_BIT] && st.locCode == LOC_NONE)
		else $error("correctable clear left flag or code");
	a_clear_unc: assert property (@(posedge ref_clk) disable iff (rst)
		(w1c[UNC_BIT] && !anyCe && !anyUnc)
		|=> !st.flags[UNC_BIT] && st.locCode == LOC_NONE)
		else $error("uncorrectable clear left flag or code");
	a_clear_multi: assert property (@(posedge ref_clk) disable iff (rst)
		(w1c[MULTI_BIT] && !anyCe && !anyUnc)
		|=> !st.flags[MULTI_BIT] && st.multiType == MT_NONE)
		else $error("multiple clear left flag or type");
	a_zero_keeps: assert property (@(posedge ref_clk) disable iff (rst)
		(wrFire && st.awAddr == TEM_FLAGS_OFS && st.wData[2:0] == 3'h0)
		|=> (st.flags & $past(st.flags)) == $past(st.flags))
		else $error("zero write cleared a flag");
	a_flags_sticky: assert property (@(posedge ref_clk) disable iff (rst)
		(st.flags[CE_BIT] && !w1c[CE_BIT]) |=> st.flags[CE_BIT])
		else $error("correctable flag dropped without a clear");

	// Injection: pending until used, then gone
	a_inj_clears: assert property (@(posedge ref_clk) disable iff (rst)
		(anyInj && !wrFire) |=> st.ctrl[CTL_INJ+:2] == INJ_NONE)
		else $error("injection field not returned to zero");
	a_inj_holds: assert property (@(posedge ref_clk) disable iff (rst)
		(inj && !anyInj && !wrFire) |=> st.ctrl[CTL_INJ+:2] == $past(st.ctrl[CTL_INJ+:2]))
		else $error("pending injection lost before use");
	a_inj_multi: assert property (@(posedge ref_clk) disable iff (rst)
		(anyInj && (st.flags[CE_BIT] || st.flags[UNC_BIT])) |=> st.flags[MULTI_BIT])
		else $error("injection over a record gave no multiple error");

	// Interrupt gating by the three suppress bits
	a_irq_ce_unmasked: assert property (@(posedge ref_clk) disable iff (rst)
		(st.flags[CE_BIT] && !st.ctrl[CTL_CEM]) |-> errIrq)
		else $error("unmasked correctable without interrupt");
	a_irq_unc_unmasked: assert property (@(posedge ref_clk) disable iff (rst)
		(st.flags[UNC_BIT] && !st.ctrl[CTL_UEM]) |-> errIrq)
		else $error("unmasked uncorrectable without interrupt");
	a_irq_multi_unmasked: assert property (@(posedge ref_clk) disable iff (rst)
		(st.flags[MULTI_BIT] && !st.ctrl[CTL_OFM]) |-> errIrq)
		else $error("unmasked multiple error without interrupt");
	a_irq_none: assert property (@(posedge ref_clk) disable iff (rst)
		(st.flags == 3'h0) |-> !errIrq)
		else $error("interrupt with no flag set");
	a_irq_masked: assert property (@(posedge ref_clk) disable iff (rst)
		((st.flags & ~st.ctrl[CTL_CEM+:3]) == 3'h0) |-> !errIrq)
		else $error("interrupt with every set flag suppressed");

	// Read channel answers on the next edge with the addressed word
	a_read_answer: assert property (@(posedge ref_clk) disable iff (rst)
		rdFire |=> axiRsp.rvalid && axiRsp.rdata == $past(rdVal))
		else $error("read not answered next cycle");

	// Main scenarios
	c_ce_event: cover property (@(posedge ref_clk) disable iff (rst) anyCe ##1 errIrq);
	c_injection: cover property (@(posedge ref_clk) disable iff (rst) anyInj ##1 st.flags != 3'h0);
	c_multiple: cover property (@(posedge ref_clk) disable iff (rst) $rose(st.flags[MULTI_BIT]));
	c_clear: cover property (@(posedge ref_clk) disable iff (rst) $fell(st.flags[CE_BIT]));
	c_inj_unc: cover property (@(posedge ref_clk) disable iff (rst) anyInj && anyUnc);
endmodule : tem_error_monitor

//--- bench/tem_ram_model.sv
// Model of the three RAM read paths that report reads to the monitor.
// Assumes the bench pulses one go bit per read for a single cycle.
`timescale 1ns/100ps
module tem_ram_model (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [2:0]  go,
	input  wire logic        corr,
	input  wire logic        uncorr,
	input  wire logic [31:0] addr,
	output tem_pkg::tem_rd_t instrRd,
	output tem_pkg::tem_rd_t data0Rd,
	output tem_pkg::tem_rd_t data1Rd
);
	import tem_pkg::*;
	tem_rd_t rd [3];

	// One report per read; between reads the payload flips so stale data never looks valid
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < 3; i++) begin
			if (rst) begin
				rd[i] <= '0;
			end else if (go[i]) begin
				rd[i] <= '{1'b1, corr, uncorr, addr};
			end else begin
				rd[i] <= '{1'b0, ~rd[i].corr, ~rd[i].uncorr, ~rd[i].addr};
			end
		end
	end

	// Path order matches the monitor's ports
	assign instrRd = rd[0];
	assign data0Rd = rd[1];
	assign data1Rd = rd[2];
endmodule : tem_ram_model

//--- bench/tem_error_monitor_bench.sv
// Self-checking bench for the ECC error monitor over AXI4-Lite.
// Assumes the RAM path model drives the three read reports.
`timescale 1ns/100ps
module tem_error_monitor_bench;
	import tem_pkg::*;
	logic         ref_clk;
	logic         rst;
	tem_axi_req_t axiReq;
	tem_axi_rsp_t axiRsp;
	tem_rd_t      instrRd, data0Rd, data1Rd;
	logic         errIrq;
	logic [2:0]   go;
	logic         corr, unc;
	logic [31:0]  addr, d;
	logic [1:0]   r;
	int           errors, n_checks, cycles;

	tem_error_monitor tem_error_monitor_i (.ref_clk(ref_clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
		.instrRd(instrRd), .data0Rd(data0Rd), .data1Rd(data1Rd), .errIrq(errIrq));
	tem_ram_model tem_ram_model_i (.ref_clk(ref_clk), .rst(rst), .go(go), .corr(corr), .uncorr(unc),
		.addr(addr), .instrRd(instrRd), .data0Rd(data0Rd), .data1Rd(data1Rd));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic report_and_stop();
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	// Hang guard; the whole run needs well under this
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("[FAIL] %0t timeout", $time);
			report_and_stop();
		end
	end

	task automatic chkw(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chkw

	task automatic chkb(input logic e);
		n_checks++;
		if (errIrq !== e) begin
			errors++;
			$display("[FAIL] %0t interrupt %b expected %b", $time, errIrq, e);
		end
	endtask : chkb

	// Write: address and data offered together, each released when taken
	task automatic axw(input logic [11:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		axiReq.awaddr <= {20'h0, a};
		axiReq.wdata <= v;
		axiReq.wstrb <= 4'hf;
		axiReq.awvalid <= 1'b1;
		axiReq.wvalid <= 1'b1;
		axiReq.bready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
			if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
			if (axiRsp.bvalid) break;
		end
		axiReq.bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge ref_clk);
		axiReq.araddr <= {20'h0, a};
		axiReq.arvalid <= 1'b1;
		axiReq.rready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
			if (axiRsp.rvalid) begin
				v = axiRsp.rdata;
				rs = axiRsp.rresp;
				break;
			end
		end
		axiReq.rready <= 1'b0;
	endtask : axr

	// Read, compare masked word, expect OKAY
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] v;
		logic [1:0]  rs;
		axr(a, v, rs);
		chkw(v & m, e);
		chkw({30'h0, rs}, {30'h0, RESP_OKAY});
	endtask : rdc

	// One RAM read report, then time for the two-stage record to land
	task automatic ramRead(input int sel, input logic c, input logic u, input logic [31:0] a);
		@(posedge ref_clk);
		go <= 3'(1 << sel);
		corr <= c;
		unc <= u;
		addr <= a;
		@(posedge ref_clk);
		go <= 3'h0;
		repeat (6) @(posedge ref_clk);
	endtask : ramRead

	initial begin
		axiReq = '0;
		go = 3'h0;
		corr = 1'b0;
		unc = 1'b0;
		addr = 32'h0;
		rst = 1'b1;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		// Reset values of all four registers
		for (int i = 0; i < 4; i++) rdc(TEM_FLAGS_OFS + 12'(4 * i), 32'h0, 32'hffffffff);
		chkb(1'b0);
		axr(12'hd10, d, r);
		chkw(d, 32'h0);
		chkw({30'h0, r}, {30'h0, RESP_SLVERR});
		// Genuine errors with both paths checked
		axw(TEM_CTRL_OFS, 32'h3);
		ramRead(0, 1'b1, 1'b0, 32'h100);
		rdc(TEM_FLAGS_OFS, 32'h1, 32'hffffffff);
		rdc(TEM_CODE_OFS, {29'h0, LOC_INSTR}, 32'h7);
		rdc(TEM_ADDR_OFS, 32'h100, 32'hffffffff);
		chkb(1'b1);
		axw(TEM_FLAGS_OFS, 32'h0);
		rdc(TEM_FLAGS_OFS, 32'h1, 32'hffffffff);
		ramRead(1, 1'b0, 1'b1, 32'h204);
		rdc(TEM_FLAGS_OFS, 32'h7, 32'hffffffff);
		rdc(TEM_CODE_OFS, {27'h0, MT_UNC, 3'h0}, 32'h18);
		// Masks: all suppressed, then each one opened alone
		axw(TEM_CTRL_OFS, 32'h1f);
		chkb(1'b0);
		for (int i = 0; i < 3; i++) begin
			axw(TEM_CTRL_OFS, 32'h1f & ~(32'h4 << i));
			chkb(1'b1);
		end
		axw(TEM_FLAGS_OFS, 32'h4);
		rdc(TEM_CODE_OFS, 32'h0, 32'h18);
		rdc(TEM_FLAGS_OFS, 32'h3, 32'hffffffff);
		axw(TEM_FLAGS_OFS, 32'h3);
		rdc(TEM_FLAGS_OFS, 32'h0, 32'hffffffff);
		rdc(TEM_CODE_OFS, 32'h0, 32'h7);
		chkb(1'b0);
		// Disabled paths record nothing
		axw(TEM_CTRL_OFS, 32'h1);
		ramRead(0, 1'b1, 1'b1, 32'h110);
		axw(TEM_CTRL_OFS, 32'h2);
		ramRead(2, 1'b1, 1'b0, 32'h220);
		rdc(TEM_FLAGS_OFS, 32'h0, 32'hffffffff);
		// Injection on every target and mode, with a decoy read elsewhere first
		for (int t = 0; t < 3; t++) begin
			for (int m = 1; m < 3; m++) begin
				axw(TEM_FLAGS_OFS, 32'h7);
				axw(TEM_CTRL_OFS, 32'h3 | (m << CTL_INJ) | (t << CTL_TGT));
				ramRead((t + 1) % 3, 1'b0, 1'b0, 32'h300);
				ramRead(t, 1'b0, 1'b0, 32'h400 + 32'(4 * t + m));
				rdc(TEM_FLAGS_OFS, 32'(m), 32'hffffffff);
				rdc(TEM_CODE_OFS, (t == 0) ? 32'(LOC_INSTR) : 32'(LOC_DATA), 32'h7);
				rdc(TEM_ADDR_OFS, 32'h400 + 32'(4 * t + m), 32'hffffffff);
				rdc(TEM_CTRL_OFS, 32'h3 | (t << CTL_TGT), 32'hffffffff);
			end
		end
		// Injection over an uncleared record
		axw(TEM_CTRL_OFS, 32'h3 | (32'(INJ_CE) << CTL_INJ));
		ramRead(0, 1'b0, 1'b0, 32'h500);
		rdc(TEM_FLAGS_OFS, 32'h7, 32'hffffffff);
		rdc(TEM_CODE_OFS, {27'h0, MT_CE, 3'h0}, 32'h18);
		report_and_stop();
	end
endmodule : tem_error_monitor_bench
